// [rtl/pulse_command_table_executor.sv]
// Functional notes
// RULE1 - A start with phase elements in the table zeroes phases and sets gains to one.
// RULE2 - Waveform index 0..15999 selects the stored wave; absent element plays nothing.
// RULE3 - Entry without waveform plays nothing but still applies phase and gain updates.
// RULE4 - Absent phase command leaves that channel's phase unchanged.
// RULE5 - Length in samples is at least 32, at most declared length, defaulting to it.
// RULE6 - Rate exponent 0..13, default 0, divides the sample rate by two to n.
// RULE7 - Each channel routes to port A, B or both; default is the slot binding.
// RULE8 - Filter clear flag clears the output filter state; default false.
// RULE9 - Hold-last repeats last sample, zero-fill plays zeros, for the given length.
// RULE10 - Phase command carries degrees within -180.0 inclusive to 180.0 exclusive.
// RULE11 - Phase values beyond the range are clamped, never wrapped or rejected.
// RULE12 - Phase increment flag adds to current phase; default replaces it.
// RULE13 - Gain factor -1.0..1.0; absent value reuses the register, initially 1.0.
// RULE14 - Gain increment flag adds to the stored register value; default overwrites.
// RULE15 - Gain command selects register 0..3, default 0.
// RULE16 - Each channel keeps four independent gain registers retaining their last value.
// RULE17 - The sequencer issues only loaded entries; they run in order, one at a time.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
module pulse_command_table_executor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic waveValid,
    input wire logic [13:0] waveIndex,
    input wire logic [15:0] declaredWaveLength,
    input wire logic [1:0] bindFirstRouting,
    input wire logic [1:0] bindSecondRouting,
    input wire logic lengthValid,
    input wire logic [15:0] waveLength,
    input wire logic [3:0] rateDividerExponent,
    input wire logic firstRoutingValid,
    input wire logic [1:0] firstChannelRouting,
    input wire logic secondRoutingValid,
    input wire logic [1:0] secondChannelRouting,
    input wire logic filterClearFlag,
    input wire logic zeroFillFlag,
    input wire logic holdLastFlag,
    input wire logic firstPhaseCmdValid,
    input wire logic [15:0] firstPhaseCmdValue,
    input wire logic firstPhaseCmdIncr,
    input wire logic secondPhaseCmdValid,
    input wire logic [15:0] secondPhaseCmdValue,
    input wire logic secondPhaseCmdIncr,
    input wire logic firstGainCmdValid,
    input wire logic firstGainCmdHasValue,
    input wire logic [17:0] firstGainCmdValue,
    input wire logic firstGainCmdIncr,
    input wire logic [1:0] firstGainCmdReg,
    input wire logic secondGainCmdValid,
    input wire logic secondGainCmdHasValue,
    input wire logic [17:0] secondGainCmdValue,
    input wire logic secondGainCmdIncr,
    input wire logic [1:0] secondGainCmdReg,
    output logic playStart,
    output logic [13:0] playIndex,
    output logic [15:0] playLength,
    output logic [3:0] playRateExp,
    output logic zero_fill_flag,
    output logic hold_last_flag,
    output logic [1:0] routeFirst,
    output logic [1:0] routeSecond,
    output logic filterClearPulse,
    output logic [15:0] firstPhase,
    output logic [15:0] secondPhase,
    output logic [17:0] firstGain,
    output logic [17:0] secondGain,
    output logic busy
);

    pulse_exec_pkg::state_t stReg;
    pulse_exec_pkg::state_t stNext;
    logic accept;
    logic startWr;
    logic apbDone;
    logic [1:0] phValid;
    logic [1:0][15:0] phValue;
    logic [1:0] phIncr;
    logic [1:0] gnValid;
    logic [1:0] gnHasValue;
    logic [1:0][17:0] gnValue;
    logic [1:0] gnIncr;
    logic [1:0][1:0] gnReg;

    // Saturating add keeps an increment sweep from wrapping across the limits.
    function automatic logic [15:0] clampPhase(input logic signed [16:0] v);
        if (v < 17'(pulse_exec_pkg::PHASE_MIN)) begin
            return pulse_exec_pkg::PHASE_MIN;
        end else if (v > 17'(pulse_exec_pkg::PHASE_MAX)) begin
            return pulse_exec_pkg::PHASE_MAX;
        end
        return v[15:0];
    endfunction : clampPhase

    function automatic logic [17:0] clampGain(input logic signed [18:0] v);
        if (v < 19'(pulse_exec_pkg::GAIN_MIN)) begin
            return pulse_exec_pkg::GAIN_MIN;
        end else if (v > 19'(pulse_exec_pkg::GAIN_ONE)) begin
            return pulse_exec_pkg::GAIN_ONE;
        end
        return v[17:0];
    endfunction : clampGain

    assign phValid = {secondPhaseCmdValid, firstPhaseCmdValid};
    assign phValue = {secondPhaseCmdValue, firstPhaseCmdValue};
    assign phIncr = {secondPhaseCmdIncr, firstPhaseCmdIncr};
    assign gnValid = {secondGainCmdValid, firstGainCmdValid};
    assign gnHasValue = {secondGainCmdHasValue, firstGainCmdHasValue};
    assign gnValue = {secondGainCmdValue, firstGainCmdValue};
    assign gnIncr = {secondGainCmdIncr, firstGainCmdIncr};
    assign gnReg = {secondGainCmdReg, firstGainCmdReg};

    // RULE17 one at a time
    assign accept = cmdValid && stReg.cmdReady;
    assign apbDone = psel && penable && stReg.pready;
    assign startWr = apbDone && pwrite && (paddr == pulse_exec_pkg::CTRL_OFFSET) &&
        pwdata[pulse_exec_pkg::CTRL_START_BIT];

    always_comb begin
        logic [15:0] len;
        logic [3:0] rexp;
        logic [2:0] idx;
        stNext = stReg;
        len = '0;
        rexp = '0;
        idx = '0;
        stNext.playStart = 1'b0;
        stNext.filterClearPulse = 1'b0;
        stNext.pready = 1'b0;
        stNext.pslverr = 1'b0;
        stNext.prdata = '0;

        // Registers answer one cycle into the access phase.
        if (psel && penable && !stReg.pready) begin
            stNext.pready = 1'b1;
            if (paddr == pulse_exec_pkg::CTRL_OFFSET) begin
                stNext.prdata = {31'h0, stReg.phaseInTable};
            end else if (paddr == pulse_exec_pkg::STATUS_OFFSET) begin
                stNext.prdata = {stReg.execCount, 14'h0, stReg.cmdReady, stReg.mode == pulse_exec_pkg::PLAY};
            end else if (paddr == pulse_exec_pkg::PHASE_OFFSET) begin
                stNext.prdata = {stReg.phase[1], stReg.phase[0]};
            end else if (paddr == pulse_exec_pkg::GAIN_SEL_OFFSET) begin
                stNext.prdata = {28'h0, stReg.gainSel[1], stReg.gainSel[0]};
            end else if (paddr >= pulse_exec_pkg::GAIN_BASE_OFFSET &&
                    paddr <= pulse_exec_pkg::GAIN_LAST_OFFSET && paddr[1:0] == 2'h0) begin
                idx = 3'(paddr[7:2] - pulse_exec_pkg::GAIN_BASE_OFFSET[7:2]);
                stNext.prdata = {14'h0, stReg.amp[idx[2]][idx[1:0]]};
            end else begin
                stNext.pslverr = 1'b1;
            end
        end
        if (apbDone && pwrite && paddr == pulse_exec_pkg::CTRL_OFFSET) begin
            stNext.phaseInTable = pwdata[pulse_exec_pkg::CTRL_PHASE_BIT];
        end

        unique case (stReg.mode)
            pulse_exec_pkg::IDLE: begin
                if (accept) begin
                    stNext.execCount = stReg.execCount + 16'h0001;
                    // RULE5 length bounds
                    len = lengthValid ? waveLength : declaredWaveLength;
                    if (len > declaredWaveLength) begin
                        len = declaredWaveLength;
                    end
                    if (len < pulse_exec_pkg::MIN_PLAY_LENGTH) begin
                        len = pulse_exec_pkg::MIN_PLAY_LENGTH;
                    end
                    // RULE6 rate exponent
                    rexp = (rateDividerExponent > pulse_exec_pkg::RATE_EXP_MAX) ?
                        pulse_exec_pkg::RATE_EXP_MAX : rateDividerExponent;
                    // RULE8 filter clear
                    stNext.filterClearPulse = filterClearFlag;
                    // RULE2 waveform select
                    // RULE3 skip playback
                    if (waveValid && (zeroFillFlag || holdLastFlag || waveIndex <= pulse_exec_pkg::WAVE_INDEX_MAX)) begin
                        stNext.mode = pulse_exec_pkg::PLAY;
                        // RULE6 divided playback time
                        stNext.cnt = 30'(len) << rexp;
                        stNext.playStart = 1'b1;
                        stNext.playIndex = waveIndex;
                        stNext.playLength = len;
                        stNext.playRateExp = rexp;
                        // RULE9 zero and hold
                        stNext.zero_fill_flag = zeroFillFlag;
                        stNext.hold_last_flag = holdLastFlag;
                        // RULE7 output routing
                        stNext.routeFirst = firstRoutingValid ? firstChannelRouting : bindFirstRouting;
                        stNext.routeSecond = secondRoutingValid ? secondChannelRouting : bindSecondRouting;
                    end
                    for (int ch = 0; ch < 2; ch++) begin
                        // RULE4 phase kept
                        if (phValid[ch]) begin
                            // RULE10 degree range
                            // RULE12 add or replace
                            // RULE11 phase clamp
                            if (phIncr[ch]) begin
                                stNext.phase[ch] = clampPhase(17'($signed(stReg.phase[ch])) +
                                    17'($signed(phValue[ch])));
                            end else begin
                                stNext.phase[ch] = clampPhase(17'($signed(phValue[ch])));
                            end
                        end
                        // RULE15 register select
                        stNext.gainSel[ch] = gnValid[ch] ? gnReg[ch] : 2'h0;
                        // RULE16 independent registers
                        // RULE14 add or overwrite
                        if (gnValid[ch] && gnHasValue[ch]) begin
                            if (gnIncr[ch]) begin
                                stNext.amp[ch][gnReg[ch]] = clampGain(19'($signed(stReg.amp[ch][gnReg[ch]])) +
                                    19'($signed(gnValue[ch])));
                            end else begin
                                stNext.amp[ch][gnReg[ch]] = clampGain(19'($signed(gnValue[ch])));
                            end
                        end
                        // RULE13 previous gain reused
                        stNext.gainOut[ch] = stNext.amp[ch][stNext.gainSel[ch]];
                    end
                end
            end
            pulse_exec_pkg::PLAY: begin
                if (stReg.cnt <= 30'h1) begin
                    stNext.mode = pulse_exec_pkg::IDLE;
                    stNext.cnt = '0;
                end else begin
                    stNext.cnt = stReg.cnt - 30'h1;
                end
            end
        endcase

        // RULE1 start reset
        // A start wins over an entry taken in the same cycle, so a run never begins with stale state.
        if (startWr) begin
            stNext.execCount = '0;
            if (stReg.phaseInTable) begin
                stNext.phase = '0;
                stNext.amp = {8{pulse_exec_pkg::GAIN_ONE}};
                stNext.gainOut = {2{pulse_exec_pkg::GAIN_ONE}};
            end
        end
        stNext.cmdReady = stNext.mode == pulse_exec_pkg::IDLE;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stReg <= pulse_exec_pkg::STATE_RESET;
        end else begin
            stReg <= stNext;
        end
    end

    assign prdata = stReg.prdata;
    assign pready = stReg.pready;
    assign pslverr = stReg.pslverr;
    assign cmdReady = stReg.cmdReady;
    assign playStart = stReg.playStart;
    assign playIndex = stReg.playIndex;
    assign playLength = stReg.playLength;
    assign playRateExp = stReg.playRateExp;
    assign zero_fill_flag = stReg.zero_fill_flag;
    assign hold_last_flag = stReg.hold_last_flag;
    assign routeFirst = stReg.routeFirst;
    assign routeSecond = stReg.routeSecond;
    assign filterClearPulse = stReg.filterClearPulse;
    assign firstPhase = stReg.phase[0];
    assign secondPhase = stReg.phase[1];
    assign firstGain = stReg.gainOut[0];
    assign secondGain = stReg.gainOut[1];
    assign busy = stReg.mode == pulse_exec_pkg::PLAY;

    start_reset_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
        startWr && stReg.phaseInTable |=> firstPhase == 16'h0000 && secondPhase == 16'h0000 &&
            firstGain == pulse_exec_pkg::GAIN_ONE && secondGain == pulse_exec_pkg::GAIN_ONE)
        else $error("Start did not reset phase and gain.");

    wave_index_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
        accept && waveValid && waveIndex <= pulse_exec_pkg::WAVE_INDEX_MAX |=>
            playStart && playIndex == $past(waveIndex))
        else $error("Valid waveform did not start playback.");

    no_wave_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
        accept && !waveValid |=> !playStart && !busy)
        else $error("Entry without waveform started playback.");

    phase_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
        accept && !firstPhaseCmdValid && !startWr |=> $stable(firstPhase))
        else $error("Absent phase command changed the phase.");

    length_bound_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
        playStart |-> playLength >= pulse_exec_pkg::MIN_PLAY_LENGTH)
        else $error("Playback length below the minimum.");

    rate_time_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
        playStart && playLength == 16'h0020 && playRateExp == 4'h0 |-> busy[*8] ##24 busy ##1 !busy)
        else $error("Playback time does not match length and divider.");

    route_default_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
        accept && waveValid && !firstRoutingValid && waveIndex <= pulse_exec_pkg::WAVE_INDEX_MAX |=>
            routeFirst == $past(bindFirstRouting))
        else $error("Default routing not taken from the slot binding.");

    filter_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
        accept |=> filterClearPulse == $past(filterClearFlag))
        else $error("Filter clear pulse does not follow the flag.");

    phase_range_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
        $signed(firstPhase) >= pulse_exec_pkg::PHASE_MIN && $signed(firstPhase) <= pulse_exec_pkg::PHASE_MAX)
        else $error("Phase left the clamped range.");

    gain_reuse_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
        accept && firstGainCmdValid && !firstGainCmdHasValue && !startWr |=>
            firstGain == $past(stReg.amp[0][firstGainCmdReg]))
        else $error("Gain without value did not reuse the register.");

    gain_select_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
        accept && !secondGainCmdValid && !startWr |=> stReg.gainSel[1] == 2'h0)
        else $error("Absent gain command did not select register zero.");

    zero_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
        accept && waveValid && (zeroFillFlag || holdLastFlag) |=>
            playStart && zero_fill_flag == $past(zeroFillFlag) && hold_last_flag == $past(holdLastFlag))
        else $error("Zero-fill or hold-last flag not carried to playback.");

    phase_replace_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
        accept && firstPhaseCmdValid && !firstPhaseCmdIncr && !startWr &&
            $signed(firstPhaseCmdValue) >= pulse_exec_pkg::PHASE_MIN &&
            $signed(firstPhaseCmdValue) <= pulse_exec_pkg::PHASE_MAX |=> firstPhase == $past(firstPhaseCmdValue))
        else $error("Absolute phase did not replace the phase.");

    phase_clamp_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
        accept && firstPhaseCmdValid && !firstPhaseCmdIncr && !startWr &&
            $signed(firstPhaseCmdValue) < pulse_exec_pkg::PHASE_MIN |=> firstPhase == pulse_exec_pkg::PHASE_MIN)
        else $error("Low phase value was not clamped to the lower limit.");

    gain_overwrite_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
        accept && firstGainCmdValid && firstGainCmdHasValue && !firstGainCmdIncr && !startWr &&
            $signed(firstGainCmdValue) >= pulse_exec_pkg::GAIN_MIN &&
            $signed(firstGainCmdValue) <= pulse_exec_pkg::GAIN_ONE |=> firstGain == $past(firstGainCmdValue))
        else $error("Gain overwrite did not take the given value.");

endmodule : pulse_command_table_executor

// [rtl/pulse_exec_pkg.sv]
package pulse_exec_pkg;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] PHASE_OFFSET = 8'h08;
    localparam logic [7:0] GAIN_SEL_OFFSET = 8'h0c;
    localparam logic [7:0] GAIN_BASE_OFFSET = 8'h10;
    localparam logic [7:0] GAIN_LAST_OFFSET = 8'h2c;
    localparam int CTRL_PHASE_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam logic [13:0] WAVE_INDEX_MAX = 14'd15999;
    localparam logic [15:0] MIN_PLAY_LENGTH = 16'h0020;
    localparam logic [3:0] RATE_EXP_MAX = 4'hd;
    // Phase is held in 1/128 degree steps.
    localparam logic signed [15:0] PHASE_MIN = 16'sha600;
    localparam logic signed [15:0] PHASE_MAX = 16'sh59ff;
    localparam logic signed [15:0] PHASE_ZERO = 16'sh0000;
    // Gain is held as a signed fraction with 16 fraction bits.
    localparam logic signed [17:0] GAIN_ONE = 18'sh10000;
    localparam logic signed [17:0] GAIN_MIN = 18'sh30000;

    typedef enum logic {IDLE, PLAY} mode_t;

    typedef struct packed {
        mode_t mode;
        logic [29:0] cnt;
        logic [1:0][3:0][17:0] amp;
        logic [1:0][15:0] phase;
        logic [1:0][1:0] gainSel;
        logic [1:0][17:0] gainOut;
        logic phaseInTable;
        logic [15:0] execCount;
        logic cmdReady;
        logic playStart;
        logic [13:0] playIndex;
        logic [15:0] playLength;
        logic [3:0] playRateExp;
        logic zero_fill_flag;
        logic hold_last_flag;
        logic [1:0] routeFirst;
        logic [1:0] routeSecond;
        logic filterClearPulse;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

    localparam state_t STATE_RESET = '{mode: IDLE, amp: {8{GAIN_ONE}}, gainOut: {2{GAIN_ONE}},
        cmdReady: 1'b1, default: '0};
endpackage : pulse_exec_pkg

// [test/sequencer_model.sv]
`timescale 1ns/1ps
module sequencer_model (
    input wire logic clk,
    input wire logic cmdReady,
    output logic cmdValid
);
    initial cmdValid = 1'h0;

    // one at a time
    // The entry stays offered until an edge that finds the executor ready, so a busy executor is never overrun.
    task automatic issue();
        cmdValid <= 1'h1;
        @(posedge clk);
        while (cmdReady !== 1'h1) @(posedge clk);
        cmdValid <= 1'h0;
    endtask : issue
endmodule : sequencer_model

// [test/pulse_command_table_executor_test.sv]
`timescale 1ns/1ps
module pulse_command_table_executor_test;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic psel, penable, pwrite, pready, pslverr, cmdValid, cmdReady, waveValid, lengthValid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic er, playStart, zero_fill_flag, hold_last_flag, filterClearPulse, busy;
    logic [13:0] waveIndex, playIndex;
    logic [15:0] declaredWaveLength, waveLength, firstPhaseCmdValue, secondPhaseCmdValue;
    logic [15:0] playLength, firstPhase, secondPhase;
    logic [1:0] bindFirstRouting, bindSecondRouting, firstChannelRouting, secondChannelRouting;
    logic [1:0] firstGainCmdReg, secondGainCmdReg, routeFirst, routeSecond;
    logic [3:0] rateDividerExponent, playRateExp;
    logic firstRoutingValid, secondRoutingValid, filterClearFlag, zeroFillFlag, holdLastFlag;
    logic firstPhaseCmdValid, firstPhaseCmdIncr, secondPhaseCmdValid, secondPhaseCmdIncr;
    logic firstGainCmdValid, firstGainCmdHasValue, firstGainCmdIncr;
    logic secondGainCmdValid, secondGainCmdHasValue, secondGainCmdIncr;
    logic [17:0] firstGainCmdValue, secondGainCmdValue, firstGain, secondGain;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    pulse_command_table_executor dut_u (.*);
    sequencer_model seq_u (.clk(clk), .cmdReady(cmdReady), .cmdValid(cmdValid));

    always #2.5 clk = ~clk;

    // The whole run needs well under a thousand cycles; the ceiling leaves ample margin.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : apb

    task automatic blank();
        {waveValid, lengthValid, firstRoutingValid, secondRoutingValid} <= 4'h0;
        {filterClearFlag, zeroFillFlag, holdLastFlag} <= 3'h0;
        {firstPhaseCmdValid, secondPhaseCmdValid, firstGainCmdValid, secondGainCmdValid} <= 4'h0;
        {firstPhaseCmdIncr, secondPhaseCmdIncr, firstGainCmdIncr, secondGainCmdIncr} <= 4'h0;
        {firstGainCmdHasValue, secondGainCmdHasValue} <= 2'h0;
    endtask : blank

    // Entry valid and flag bits are released at the taking edge; value fields such as rateDividerExponent carry into the next entry.
    task automatic send();
        seq_u.issue();
        blank();
        @(negedge clk);
    endtask : send

    task automatic play(input logic [1:0] rf, input logic fc, input int len);
        int n;
        n = 0;
        send();
        check(playStart, 1'h1);
        check(routeFirst, rf);
        check(filterClearPulse, fc);
        check(cmdReady, 1'h0);
        while (busy === 1'h1) begin
            n++;
            @(negedge clk);
        end
        check(n, len);
        @(posedge clk);
    endtask : play

    task automatic gainEntry(input logic hv, input logic inc, input logic [1:0] r, input logic [17:0] v);
        firstGainCmdValid <= 1'h1;
        firstGainCmdHasValue <= hv;
        firstGainCmdIncr <= inc;
        firstGainCmdReg <= r;
        firstGainCmdValue <= v;
        send();
        check(playStart, 1'h0);
    endtask : gainEntry

    task automatic phaseEntry(input logic inc, input logic [15:0] v, input logic [15:0] exp);
        firstPhaseCmdValid <= 1'h1;
        firstPhaseCmdIncr <= inc;
        firstPhaseCmdValue <= v;
        send();
        check(firstPhase, exp);
        check(secondPhase, 16'h0000);
        @(posedge clk);
    endtask : phaseEntry

    task automatic resetValues();
        int i;
        check(cmdReady, 1'h1);
        check(firstGain, 18'h10000);
        check(secondGain, 18'h10000);
        for (i = 0; i < 8; i++) begin
            apb(1'h0, pulse_exec_pkg::GAIN_BASE_OFFSET + 8'(4 * i), 32'h0);
            check(rd, 32'h00010000);
        end
        apb(1'h0, 8'h30, 32'h0);
        check(er, 1'h1);
        check(rd, 32'h0);
    endtask : resetValues

    task automatic gainScenario();
        gainEntry(1'h1, 1'h0, 2'h1, 18'h08000);
        check(firstGain, 18'h08000);
        @(posedge clk);
        gainEntry(1'h1, 1'h1, 2'h1, 18'h04000);
        check(firstGain, 18'h0c000);
        @(posedge clk);
        gainEntry(1'h0, 1'h0, 2'h0, 18'h0);
        check(firstGain, 18'h10000);
        @(posedge clk);
        gainEntry(1'h0, 1'h0, 2'h1, 18'h0);
        check(firstGain, 18'h0c000);
        @(posedge clk);
        gainEntry(1'h1, 1'h1, 2'h1, 18'h08000);
        check(firstGain, 18'h10000);
        @(posedge clk);
        gainEntry(1'h1, 1'h0, 2'h2, pulse_exec_pkg::GAIN_MIN);
        check(firstGain, 18'h30000);
        @(posedge clk);
        apb(1'h0, 8'h24, 32'h0);
        check(rd, 32'h00010000);
    endtask : gainScenario

    task automatic playScenario();
        waveValid <= 1'h1;
        waveIndex <= pulse_exec_pkg::WAVE_INDEX_MAX;
        declaredWaveLength <= 16'h0028;
        bindFirstRouting <= 2'h2;
        bindSecondRouting <= 2'h1;
        rateDividerExponent <= 4'h1;
        play(2'h2, 1'h0, 80);
        check(playIndex, 14'h3e7f);
        check(routeSecond, 2'h1);
        check(playRateExp, 4'h1);
        check(playLength, 16'h0028);
        waveValid <= 1'h1;
        zeroFillFlag <= 1'h1;
        lengthValid <= 1'h1;
        waveLength <= 16'h0005;
        firstRoutingValid <= 1'h1;
        firstChannelRouting <= 2'h3;
        rateDividerExponent <= 4'h0;
        filterClearFlag <= 1'h1;
        play(2'h3, 1'h1, 32);
        check(zero_fill_flag, 1'h1);
        waveValid <= 1'h1;
        holdLastFlag <= 1'h1;
        lengthValid <= 1'h1;
        waveLength <= 16'h0030;
        play(2'h2, 1'h0, 40);
        check(hold_last_flag, 1'h1);
        waveValid <= 1'h1;
        waveIndex <= 14'h3e80;
        send();
        check(playStart, 1'h0);
        check(busy, 1'h0);
        @(posedge clk);
    endtask : playScenario

    task automatic startScenario();
        apb(1'h1, pulse_exec_pkg::CTRL_OFFSET, 32'h1);
        apb(1'h1, pulse_exec_pkg::CTRL_OFFSET, 32'h3);
        apb(1'h0, 8'h18, 32'h0);
        check(rd, 32'h00010000);
        check(firstPhase, 16'h0000);
        apb(1'h0, pulse_exec_pkg::STATUS_OFFSET, 32'h0);
        check(rd, 32'h00000002);
    endtask : startScenario

    initial begin
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        {waveIndex, declaredWaveLength, waveLength, rateDividerExponent} <= '0;
        {bindFirstRouting, bindSecondRouting, firstChannelRouting, secondChannelRouting} <= '0;
        {firstPhaseCmdValue, secondPhaseCmdValue, firstGainCmdValue, secondGainCmdValue} <= '0;
        {firstGainCmdReg, secondGainCmdReg} <= '0;
        blank();
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        resetValues();
        gainScenario();
        phaseEntry(1'h0, 16'h1000, 16'h1000);
        phaseEntry(1'h1, 16'h5000, 16'h59ff);
        phaseEntry(1'h0, 16'h8000, 16'ha600);
        phaseEntry(1'h1, 16'h0100, 16'ha700);
        playScenario();
        startScenario();
        report_and_stop();
    end
endmodule : pulse_command_table_executor_test
